// file: logic/peripheral_transfer_port.sv
// Peripheral register port reached through the 16-bit transfer buffer
`include "ptp_defines.svh"
module peripheral_transfer_port (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire ptp_pkg::request_s req,
  input  wire logic [7:0]        shift_in,
  input  wire ptp_pkg::word_t    freq_count,
  input  wire logic [11:0]       timer_count,
  output ptp_pkg::word_t         load_data,
  output logic                   load_valid,
  output logic [5:0]             cmp_level,
  output logic [7:0]             shift_out,
  output logic [23:0]            pwm_duty,
  output logic [63:0]            segments,
  output logic [7:0]             port_x,
  output logic [6:0]             clkgen,
  output ptp_pkg::word_t         addr_reg,
  output ptp_pkg::word_t         synth_div,
  output ptp_pkg::word_t         key_source
);
  import ptp_pkg::*;

  state_s st;
  state_s next_st;
  logic [6:0]   seg_slot;
  logic [11:0]  tmod_q;
  logic         store_known;
  logic         load_known;
  logic [176:0] reg_view;

  // Segment group index relative to its first address
  assign seg_slot = req.addr - `ADDR_SEG0;

  // Views of the register state for the checks below
  assign tmod_q   = st.tmod;
  assign reg_view = {cmp_level, shift_out, pwm_duty, segments, port_x, clkgen, addr_reg,
                     synth_div, key_source, tmod_q};

  // Addresses with a register behind them, per direction
  assign store_known = req.addr inside {`ADDR_CMP_LEVEL, `ADDR_SHIFT, `ADDR_PWM0, `ADDR_PWM1,
                                        `ADDR_PWM2, [`ADDR_SEG0:`ADDR_SEG7], `ADDR_CLKGEN,
                                        `ADDR_ADDRREG, `ADDR_SYNTH, `ADDR_KEYSRC, `ADDR_TMOD};
  assign load_known  = req.addr inside {`ADDR_CMP_LEVEL, `ADDR_SHIFT, `ADDR_PWM0, `ADDR_PWM1,
                                        `ADDR_PWM2, `ADDR_CLKGEN, `ADDR_ADDRREG, `ADDR_SYNTH,
                                        `ADDR_KEYSRC, `ADDR_FREQCNT, `ADDR_TMOD, `ADDR_TCNT};

  // Store decode and load mux
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    if (req.store_to_peripheral) begin
      // Group 4 shares its address with the first port group; both take the byte
      case (req.addr)
        `ADDR_CMP_LEVEL: next_st.cmp_level = req.transfer_buffer[`CMP_W-1:0];
        `ADDR_SHIFT:     next_st.shift_out = req.transfer_buffer[`BYTE_W-1:0];
        `ADDR_PWM0, `ADDR_PWM1, `ADDR_PWM2:
          next_st.pwm[req.addr[1:0] - 2'h1] = req.transfer_buffer[`BYTE_W-1:0];
        `ADDR_CLKGEN:    next_st.clkgen = req.transfer_buffer[`CLK_W-1:0];
        `ADDR_ADDRREG:   next_st.addr_reg = req.transfer_buffer;
        `ADDR_SYNTH:     next_st.synth = req.transfer_buffer;
        `ADDR_KEYSRC:    next_st.keysrc = req.transfer_buffer;
        `ADDR_TMOD:      next_st.tmod = req.transfer_buffer[`TMR_W-1:0];
        default: ; // Read-only and unused addresses keep all state
      endcase
      if (req.addr >= `ADDR_SEG0 && req.addr <= `ADDR_SEG7)
        next_st.seg[seg_slot[2:0]] = req.transfer_buffer[`BYTE_W-1:0];
      if (req.addr == `ADDR_PORTX)
        next_st.portx = req.transfer_buffer[`BYTE_W-1:0];
    end else if (req.load_from_peripheral) begin
      next_st.rvalid = 1'b1;
      case (req.addr)
        `ADDR_CMP_LEVEL: next_st.rdata = {10'h000, st.cmp_level};
        `ADDR_SHIFT:     next_st.rdata = {8'h00, shift_in};
        `ADDR_PWM0, `ADDR_PWM1, `ADDR_PWM2:
          next_st.rdata = {8'h00, st.pwm[req.addr[1:0] - 2'h1]};
        `ADDR_CLKGEN:    next_st.rdata = {9'h000, st.clkgen};
        `ADDR_ADDRREG:   next_st.rdata = st.addr_reg;
        `ADDR_SYNTH:     next_st.rdata = st.synth;
        `ADDR_KEYSRC:    next_st.rdata = st.keysrc;
        `ADDR_FREQCNT:   next_st.rdata = freq_count;
        `ADDR_TMOD:      next_st.rdata = {4'h0, st.tmod};
        `ADDR_TCNT:      next_st.rdata = {4'h0, timer_count};
        default:         next_st.rdata = `UNDEF_WORD;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.seg <= {8{`SEG_BLANK}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops
  assign load_data  = st.rdata;
  assign load_valid = st.rvalid;
  assign cmp_level  = st.cmp_level;
  assign shift_out  = st.shift_out;
  assign pwm_duty   = st.pwm;
  assign segments   = st.seg;
  assign port_x     = st.portx;
  assign clkgen     = st.clkgen;
  assign addr_reg   = st.addr_reg;
  assign synth_div  = st.synth;
  assign key_source = st.keysrc;

  a_store_addr: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_ADDRREG |=> addr_reg == $past(req.transfer_buffer))
    else $error("address register store lost");
  a_store_cmp: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_CMP_LEVEL
      |=> cmp_level == $past(req.transfer_buffer[5:0]))
    else $error("compare level store wrong");
  a_readonly_keep: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_FREQCNT |=> $stable(synth_div) && $stable(tmod_q))
    else $error("read-only store changed state");
  a_load_freq: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_FREQCNT
      |=> load_valid && load_data == $past(freq_count))
    else $error("frequency count load wrong");
  a_load_tcnt: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_TCNT
      |=> load_data == {4'h0, $past(timer_count)})
    else $error("timer count load wrong");
  a_store_key: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_KEYSRC |=> key_source == $past(req.transfer_buffer))
    else $error("key source store lost");
  a_load_shift: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_SHIFT
      |=> load_data[7:0] == $past(shift_in))
    else $error("shift load wrong");
  a_store_synth: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_SYNTH |=> synth_div == $past(req.transfer_buffer))
    else $error("synth store lost");

  // Store side: narrow registers keep only their low bits
  a_store_shift: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_SHIFT
      |=> shift_out == $past(req.transfer_buffer[`BYTE_W-1:0]))
    else $error("shift store lost");

  a_store_portx: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_PORTX
      |=> port_x == $past(req.transfer_buffer[`BYTE_W-1:0]))
    else $error("port group store lost");

  a_seg_port: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_PORTX
      |=> port_x == segments[(`ADDR_PORTX - `ADDR_SEG0)*`BYTE_W +: `BYTE_W])
    else $error("shared port and segment byte differ");

  a_store_clkgen: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_CLKGEN
      |=> clkgen == $past(req.transfer_buffer[`CLK_W-1:0]))
    else $error("clock generator store lost");

  a_store_tmod: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_TMOD
      |=> tmod_q == $past(req.transfer_buffer[`TMR_W-1:0]))
    else $error("timer modulo store lost");

  // Each register holds its value unless its own address is stored
  a_cmp_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_CMP_LEVEL)
      |=> $stable(cmp_level))
    else $error("compare level changed without store");

  a_shift_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_SHIFT)
      |=> $stable(shift_out))
    else $error("shift data changed without store");

  a_portx_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_PORTX)
      |=> $stable(port_x))
    else $error("port group changed without store");

  a_clk_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_CLKGEN)
      |=> $stable(clkgen))
    else $error("clock generator changed without store");

  a_addr_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_ADDRREG)
      |=> $stable(addr_reg))
    else $error("address register changed without store");

  a_synth_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_SYNTH)
      |=> $stable(synth_div))
    else $error("synth value changed without store");

  a_key_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_KEYSRC)
      |=> $stable(key_source))
    else $error("key source changed without store");

  a_tmod_hold: assert property (@(posedge clock) disable iff (rst)
    !(req.store_to_peripheral && req.addr == `ADDR_TMOD)
      |=> $stable(tmod_q))
    else $error("timer modulo changed without store");

  // Stores to read-only or empty addresses leave every register alone
  a_store_unused: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && !store_known
      |=> $stable(reg_view))
    else $error("store to unused address changed state");

  a_store_tcnt: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_TCNT
      |=> $stable(reg_view))
    else $error("store to timer count changed state");

  a_store_freq: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral && req.addr == `ADDR_FREQCNT
      |=> $stable(reg_view))
    else $error("store to frequency count changed state");

  // Load answer timing: one valid pulse per accepted load, store wins
  a_load_pulse: assert property (@(posedge clock) disable iff (rst)
    req.load_from_peripheral && !req.store_to_peripheral
      |=> load_valid)
    else $error("load not answered");

  a_store_wins: assert property (@(posedge clock) disable iff (rst)
    req.store_to_peripheral
      |=> !load_valid && $stable(load_data))
    else $error("store also answered as load");

  a_valid_idle: assert property (@(posedge clock) disable iff (rst)
    !req.load_from_peripheral
      |=> !load_valid)
    else $error("load valid without load");

  a_load_stands: assert property (@(posedge clock) disable iff (rst)
    !(req.load_from_peripheral && !req.store_to_peripheral)
      |=> $stable(load_data))
    else $error("load data changed without load");

  a_load_quiet: assert property (@(posedge clock) disable iff (rst)
    req.load_from_peripheral && !req.store_to_peripheral
      |=> $stable(reg_view))
    else $error("load disturbed a register");

  a_load_unused: assert property (@(posedge clock) disable iff (rst)
    req.load_from_peripheral && !req.store_to_peripheral && !load_known
      |=> load_data == `UNDEF_WORD)
    else $error("unused load not undefined word");

  // Load values: registers zero-extended into the buffer word
  a_load_cmp: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_CMP_LEVEL
      |=> load_data == {10'h000, $past(cmp_level)})
    else $error("compare level load wrong");

  a_load_clkgen: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_CLKGEN
      |=> load_data == {9'h000, $past(clkgen)})
    else $error("clock generator load wrong");

  a_load_addr: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_ADDRREG
      |=> load_data == $past(addr_reg))
    else $error("address register load wrong");

  a_load_synth: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_SYNTH
      |=> load_data == $past(synth_div))
    else $error("synth load wrong");

  a_load_key: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_KEYSRC
      |=> load_data == $past(key_source))
    else $error("key source load wrong");

  a_load_tmod: assert property (@(posedge clock) disable iff (rst)
    !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_TMOD
      |=> load_data == {4'h0, $past(tmod_q)})
    else $error("timer modulo load wrong");

  // Per pulse-width channel: store, hold and load of its own byte
  for (genvar c = 0; c < `PWM_CHANNELS; c++) begin : pwm_check
    a_pwm_store: assert property (@(posedge clock) disable iff (rst)
      req.store_to_peripheral && req.addr == `ADDR_PWM0 + 7'(c)
        |=> pwm_duty[c*`BYTE_W +: `BYTE_W] == $past(req.transfer_buffer[`BYTE_W-1:0]))
      else $error("pulse-width store lost");

    a_pwm_hold: assert property (@(posedge clock) disable iff (rst)
      !(req.store_to_peripheral && req.addr == `ADDR_PWM0 + 7'(c))
        |=> $stable(pwm_duty[c*`BYTE_W +: `BYTE_W]))
      else $error("pulse-width changed without store");

    a_pwm_load: assert property (@(posedge clock) disable iff (rst)
      !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_PWM0 + 7'(c)
        |=> load_data == {8'h00, $past(pwm_duty[c*`BYTE_W +: `BYTE_W])})
      else $error("pulse-width load wrong");
  end

  // Per segment group: store, hold and write-only load of its own byte
  for (genvar g = 0; g < `SEG_GROUPS; g++) begin : seg_check
    a_seg_store: assert property (@(posedge clock) disable iff (rst)
      req.store_to_peripheral && req.addr == `ADDR_SEG0 + 7'(g)
        |=> segments[g*`BYTE_W +: `BYTE_W] == $past(req.transfer_buffer[`BYTE_W-1:0]))
      else $error("segment group store lost");

    a_seg_hold: assert property (@(posedge clock) disable iff (rst)
      !(req.store_to_peripheral && req.addr == `ADDR_SEG0 + 7'(g))
        |=> $stable(segments[g*`BYTE_W +: `BYTE_W]))
      else $error("segment group changed without store");

    a_seg_load: assert property (@(posedge clock) disable iff (rst)
      !req.store_to_peripheral && req.load_from_peripheral && req.addr == `ADDR_SEG0 + 7'(g)
        |=> load_data == `UNDEF_WORD && $stable(segments))
      else $error("segment group load not undefined word");
  end
endmodule

// file: logic/ptp_defines.svh
// Peripheral addresses, field widths and reset values of the transfer port
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH
`define ADDR_CMP_LEVEL  7'h02
`define ADDR_SHIFT      7'h03
`define ADDR_PWM0       7'h05
`define ADDR_PWM1       7'h06
`define ADDR_PWM2       7'h07
`define ADDR_SEG0       7'h08
`define ADDR_SEG7       7'h0f
`define ADDR_PORTX      7'h0c
`define ADDR_CLKGEN     7'h20
`define ADDR_ADDRREG    7'h40
`define ADDR_SYNTH      7'h41
`define ADDR_KEYSRC     7'h42
`define ADDR_FREQCNT    7'h43
`define ADDR_TMOD       7'h46
`define ADDR_TCNT       7'h47
`define SEG_BLANK       8'hff
`define UNDEF_WORD      16'h0000
`define CMP_W           6
`define CLK_W           7
`define TMR_W           12
`define BYTE_W          8
`define PWM_CHANNELS    3
`define SEG_GROUPS      8
`endif

// file: logic/ptp_pkg.sv
// Types shared by the peripheral transfer port
package ptp_pkg;
  typedef logic [15:0] word_t;
  typedef struct packed {
    logic       store_to_peripheral;
    logic       load_from_peripheral;
    logic [6:0] addr;
    word_t      transfer_buffer;
  } request_s;
  typedef struct packed {
    logic [5:0]      cmp_level;
    logic [7:0]      shift_out;
    logic [2:0][7:0] pwm;
    logic [7:0][7:0] seg;
    logic [7:0]      portx;
    logic [6:0]      clkgen;
    word_t           addr_reg;
    word_t           synth;
    word_t           keysrc;
    logic [11:0]     tmod;
    word_t           rdata;
    logic            rvalid;
  } state_s;
endpackage

// file: verification/core_model.sv
// Processor core model issuing one peripheral store or load per cycle
module core_model (
  input  wire logic        clock,
  output ptp_pkg::request_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptp_pkg::*;

  // Idle until the first transfer
  initial begin
    req = '0;
  end

  // Drive one request, held across the taking edge, called at a falling edge
  task automatic xfer(input logic st, input logic ld, input logic [6:0] a, input word_t d);
    req <= '{st, ld, a, d};
    @(posedge clock);
    @(negedge clock);
  endtask
endmodule

// file: verification/peripheral_transfer_port_test.sv
// Self-checking bench for the peripheral transfer port
module peripheral_transfer_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ptp_pkg::*;
  logic        clock = 0;
  logic        rst = 1;
  request_s    req;
  logic [7:0]  shift_in = 0, shift_out, port_x, e_sh = 0, e_px = 0;
  word_t       freq_count = 0, load_data, addr_reg, synth_div, key_source;
  logic [11:0] timer_count = 0, e_tm = 0;
  logic        load_valid;
  logic [5:0]  cmp_level, e_cmp = 0;
  logic [23:0] pwm_duty, e_pwm = 0;
  logic [63:0] segments, e_seg = '1;
  logic [63:0] seg_used = 64'h7f7f077f7f7f0f7f; // Used bits per group, group 0 lowest
  logic [6:0]  clkgen, e_clk = 0, a;
  word_t       e_ar = 0, e_syn = 0, e_key = 0, d;
  logic [31:0] r;
  integer      seed = 19286, fail_count = 0, num_checks = 0, i;

  // 20 MHz clock
  always #25 clock = ~clock;

  core_model i_core_model (.clock(clock), .req(req));
  peripheral_transfer_port i_peripheral_transfer_port (.clock(clock), .rst(rst), .req(req),
    .shift_in(shift_in), .freq_count(freq_count), .timer_count(timer_count),
    .load_data(load_data), .load_valid(load_valid), .cmp_level(cmp_level),
    .shift_out(shift_out), .pwm_duty(pwm_duty), .segments(segments), .port_x(port_x),
    .clkgen(clkgen), .addr_reg(addr_reg), .synth_div(synth_div), .key_source(key_source));

  // Shadow of the register outputs after a store, narrow registers keep low bits
  task automatic upd(input logic [6:0] a, input word_t d);
    case (a)
      7'h02: e_cmp = d[5:0];
      7'h03: e_sh = d[7:0];
      7'h05, 7'h06, 7'h07: e_pwm[(a-7'h05)*8 +: 8] = d[7:0];
      7'h20: e_clk = d[6:0];
      7'h40: e_ar = d;
      7'h41: e_syn = d;
      7'h42: e_key = d;
      7'h46: e_tm = d[11:0];
      default: ;
    endcase
    if (a inside {[7'h08:7'h0f]}) e_seg[(a-7'h08)*8 +: 8] = d[7:0];
    if (a == 7'h0c) e_px = d[7:0];
  endtask

  // Expected load answer, write-only and unused places read as zero
  function automatic word_t exp_load(input logic [6:0] a);
    case (a)
      7'h02: return {10'h000, e_cmp};
      7'h03: return {8'h00, shift_in};
      7'h05, 7'h06, 7'h07: return {8'h00, e_pwm[(a-7'h05)*8 +: 8]};
      7'h20: return {9'h000, e_clk};
      7'h40: return e_ar;
      7'h41: return e_syn;
      7'h42: return e_key;
      7'h43: return freq_count;
      7'h46: return {4'h0, e_tm};
      7'h47: return {4'h0, timer_count};
      default: return 16'h0000;
    endcase
  endfunction

  // Compare all register outputs with the shadow
  task automatic cmp_outs();
    num_checks++;
    if ({cmp_level, shift_out, pwm_duty, segments & seg_used, port_x, clkgen, addr_reg,
         synth_div, key_source} !== {e_cmp, e_sh, e_pwm, e_seg & seg_used, e_px, e_clk,
         e_ar, e_syn, e_key}) begin
      fail_count++;
      $display("ERROR %0t outputs differ after access to %h", $time, a);
    end
  endtask

  // Compare the load answer and its one-cycle valid pulse
  task automatic cmp_load(input logic v, input word_t e);
    num_checks++;
    if (load_valid !== v || (v && load_data !== e)) begin
      fail_count++;
      $display("ERROR %0t load at %h gave %h valid %b", $time, a, load_data, load_valid);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reset, then store and load back every address with random data, all ones at addresses 2 and 70
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 0;
    a = 0;
    cmp_outs();
    $display("reset values done");
    for (i = 0; i < 128; i++) begin
      a = i[6:0];
      d = (i == 70 || i == 2) ? 16'hffff : 16'($random(seed));
      i_core_model.xfer(1'b1, 1'b0, a, d);
      upd(a, d);
      cmp_outs();
      cmp_load(1'b0, 16'h0000);
      r = $random(seed);
      shift_in = r[7:0];
      freq_count = r[23:8];
      timer_count = {r[31:24], r[3:0]};
      i_core_model.xfer(1'b0, 1'b1, a, 16'h0000);
      cmp_load(1'b1, exp_load(a));
      cmp_outs();
    end
    i_core_model.xfer(1'b0, 1'b0, 7'h00, 16'h0000);
    $display("address sweep done");
    test_done();
  end
endmodule
